/* dv/cdt_timer_chk.sv */
// Purpose: Port-level checks of the countdown timer
// Assumes: Zero-wait APB, read data captured in the setup cycle
// Notes:   Control and load are mirrored from observed writes
`timescale 1ns/1ps
`include "cdt_timer_defines.vh"
module cdt_timer_chk #(
  parameter [31:0] ID_VALUE = 32'h0
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire dbg_halt,
  input wire timer_irq
);
  reg [31:0] ctl_r;
  reg [31:0] load_r;
  wire acc_wr = psel && penable && pwrite;
  wire acc_rd = psel && penable && !pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 32'h003e0020;
      load_r <= 32'h0;
    end else if (acc_wr) begin
      if (paddr == `CDT_OFF_CONTROL)
        ctl_r <= pwdata & `CDT_CTL_MASK;
      if (paddr == `CDT_OFF_LOAD || paddr == `CDT_OFF_RELOAD)
        load_r <= pwdata;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_irq_ie; timer_irq |-> ctl_r[5]; endproperty
  a_irq_ie: assert property (p_irq_ie) else $error("irq while disabled");
  property p_clr; acc_wr && paddr == `CDT_OFF_IRQ_CLEAR && !ctl_r[7] |=> !timer_irq; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_id; acc_rd && paddr == `CDT_OFF_IRQ_CLEAR |-> prdata == ID_VALUE; endproperty
  a_id: assert property (p_id) else $error("bad id word");
  property p_idq; acc_rd && paddr == `CDT_OFF_IRQ_CLEAR && !ctl_r[7] |=> $stable(timer_irq);
  endproperty
  a_idq: assert property (p_idq) else $error("read disturbed irq");
  property p_raw; acc_rd && paddr == `CDT_OFF_RAW_IRQ |-> prdata[31:1] == 31'h0 &&
    (!$past(ctl_r[5]) || prdata[0] == $past(timer_irq)); endproperty
  a_raw: assert property (p_raw) else $error("bad raw status");
  property p_msk; acc_rd && paddr == `CDT_OFF_MASKED_IRQ |-> prdata == {31'h0, $past(timer_irq)};
  endproperty
  a_msk: assert property (p_msk) else $error("bad masked status");
  property p_ctl; acc_rd && paddr == `CDT_OFF_CONTROL |-> prdata == ctl_r; endproperty
  a_ctl: assert property (p_ctl) else $error("bad control");
  property p_rld; acc_rd && paddr == `CDT_OFF_RELOAD |-> prdata == load_r; endproperty
  a_rld: assert property (p_rld) else $error("reload not shared");
  property p_w16; acc_rd && paddr == `CDT_OFF_VALUE && !ctl_r[1] |-> prdata[31:16] == 16'h0;
  endproperty
  a_w16: assert property (p_w16) else $error("value above 16 bits");
endmodule // cdt_timer_chk
bind cdt_timer cdt_timer_chk #(.ID_VALUE(ID_VALUE)) u_cdt_timer_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dbg_halt(dbg_halt), .timer_irq(timer_irq));

/* dv/cdt_timer_tb.sv */
// Purpose: Directed register test of the countdown timer
// Assumes: Zero-wait APB slave, pclk 25 MHz
// Notes:   Rate windows rely on reads spaced three cycles apart
`timescale 1ns/1ps
`include "cdt_timer_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module cdt_timer_tb;
  localparam [31:0] ID = 32'h5a5a0f0f; // Arbitrary identification word
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0;
  reg dbg_halt = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire timer_irq;
  reg [31:0] d;
  reg slv;
  integer i;
  int errors = 0;
  int samples_checked = 0;
  cdt_timer #(.ID_VALUE(ID)) u_cdt_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt), .timer_irq(timer_irq));
  initial forever #20 pclk = ~pclk;
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // APB master
  // ----------------------------------------
  task xfer(input [11:0] a, input w, input [31:0] wd, output [31:0] rv);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 8) begin
        errors++;
        final_report;
      end
      @(posedge pclk);
    end
    rv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [11:0] a, input [31:0] v);
    reg [31:0] x;
    xfer(a, 1'b1, v, x);
  endtask
  task rd(input [11:0] a, output [31:0] v);
    xfer(a, 1'b0, 32'h0, v);
  endtask
  // Count change of a counter across n reads, three cycles apart
  task rate(input [9:0] pd, input [31:0] c, input [11:0] a, input integer n, input h);
    reg [31:0] v0;
    reg [31:0] v1;
    dbg_halt <= h;
    wr(`CDT_OFF_PREDIV, {22'h0, pd});
    wr(`CDT_OFF_LOAD, 32'hffff);
    wr(`CDT_OFF_CONTROL, c);
    rd(a, v0);
    for (i = 1; i < n; i++) rd(a, v1);
    d = (a == `CDT_OFF_FREE_RUN) ? v1 - v0 : v0 - v1;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CDT_OFF_CONTROL, d);
    `CHK(d, 32'h003e0020);
    rd(`CDT_OFF_PREDIV, d);
    `CHK(d, 32'h0000007d);
    rd(12'h0fc, d);
    `CHK(slv, 1'b1);
    wr(`CDT_OFF_CONTROL, 32'hff00ff51);
    rd(`CDT_OFF_CONTROL, d);
    `CHK(d, 32'h00000341);
    $display("test fields done");
    wr(`CDT_OFF_PREDIV, 32'h0);
    wr(`CDT_OFF_LOAD, 32'h3);
    wr(`CDT_OFF_CONTROL, 32'h82);
    d = 32'h0;
    for (i = 0; i < 20 && d[0] !== 1'b1; i++) rd(`CDT_OFF_RAW_IRQ, d);
    `CHK(d, 32'h1);
    `CHK(timer_irq, 1'b0);
    wr(`CDT_OFF_CONTROL, 32'h22);
    @(negedge pclk);
    `CHK(timer_irq, 1'b1);
    rd(`CDT_OFF_MASKED_IRQ, d);
    `CHK(d, 32'h1);
    rd(`CDT_OFF_IRQ_CLEAR, d);
    `CHK(d, ID);
    `CHK(timer_irq, 1'b1);
    wr(`CDT_OFF_IRQ_CLEAR, 32'h0);
    @(negedge pclk);
    `CHK(timer_irq, 1'b0);
    `CHK(pready, 1'b1);
    $display("test pending done");
    wr(`CDT_OFF_LOAD, 32'h00012345);
    rd(`CDT_OFF_VALUE, d);
    `CHK(d, 32'h00012345);
    wr(`CDT_OFF_CONTROL, 32'h20);
    wr(`CDT_OFF_LOAD, 32'h00012345);
    rd(`CDT_OFF_VALUE, d);
    `CHK(d, 32'h2345);
    wr(`CDT_OFF_RELOAD, 32'h7);
    rd(`CDT_OFF_VALUE, d);
    `CHK(d, 32'h2345);
    rd(`CDT_OFF_LOAD, d);
    `CHK(d, 32'h7);
    $display("test reload done");
    rate(10'h0, 32'h84, `CDT_OFF_VALUE, 17, 1'b0);
    `CHK(d, 32'h3);
    rate(10'h0, 32'h88, `CDT_OFF_VALUE, 257, 1'b0);
    `CHK(d, 32'h3);
    rate(10'h2, 32'h80, `CDT_OFF_VALUE, 2, 1'b0);
    `CHK(d, 32'h1);
    rate(10'h2, 32'h8c, `CDT_OFF_VALUE, 2, 1'b0);
    `CHK(d, 32'h1);
    rate(10'h2, 32'h00, `CDT_OFF_VALUE, 2, 1'b0);
    `CHK(d, 32'h0);
    rate(10'h2, 32'h180, `CDT_OFF_VALUE, 3, 1'b1);
    `CHK(d, 32'h0);
    rate(10'h2, 32'h80, `CDT_OFF_VALUE, 3, 1'b1);
    `CHK(d, 32'h2);
    rate(10'h2, 32'h00020200, `CDT_OFF_FREE_RUN, 2, 1'b0);
    `CHK(d, 32'h1);
    rate(10'h2, 32'h00020300, `CDT_OFF_FREE_RUN, 3, 1'b1);
    `CHK(d, 32'h0);
    $display("test rates done");
    final_report;
  end
endmodule // cdt_timer_tb

/* verilog/cdt_div.v */
// Purpose: Programmable clock-enable divider, one tick per (div + 1) cycles
// Assumes: div may change at any time; the running count is compared with the new value at once
// Notes:   Counter holds while run is low
`timescale 1ns/1ps
module cdt_div #(
  parameter W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [W-1:0] div,
  output wire tick
);

  reg [W-1:0] cnt_r;

  // Compare with >= so a lowered divisor cannot strand the counter
  assign tick = run & (cnt_r >= div);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {W{1'b0}};
    end else if (tick) begin
      cnt_r <= {W{1'b0}};
    end else if (run) begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // cdt_div

/* verilog/cdt_sync.v */
// Purpose: Three-stage synchroniser with agreement filter for a pin level
// Assumes: Input is asynchronous to pclk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module cdt_sync (
  input wire pclk,
  input wire presetn,
  input wire async_in,
  output reg level_r
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

endmodule // cdt_sync

/* verilog/cdt_timer.v */
// Purpose: Countdown timer with pending flag, interrupt mask, reload and free-running counter
// Assumes: APB3 slave with zero wait states; debug halt arrives asynchronously
// Notes:   Read data is captured in the setup cycle of a read
// Behaviour
// - Control 23:16 is free-run prescale, reset 0x3e, rate pclk/(prescale+1)
// - Control bit 8 set stops counting while the host is debug-halted
// - Control bit 6 is stored only; the countdown always reloads
// - Control bit 5 gates the pending flag onto the interrupt output
// - Prescale codes 00 and 11 apply no extra division
// - Control bit 0 is stored only; no one-shot mode exists
// - Any write to the clear register clears the pending flag, unless a zero event falls in the same cycle
// - Reading the clear register returns a fixed identification word
// - Raw status is read-only, pending flag at bit 0, zeros above
// - Pending flag sets whenever the count reaches zero, enable or not
// - Interrupt output rises only with the enable bit set
// - Masked status bit 0 equals pending AND enable, the line itself
// - Reload and load registers share one stored value
// - Writing reload leaves the current count untouched until zero
// - Writing load copies the value into the count at once
// - Timer tick is pclk divided by ten-bit pre-divider plus one
// - Control bit 9 enables the 32-bit rolling free-running counter
// - The free-running counter also stops under debug halt with bit 8
`timescale 1ns/1ps
`include "cdt_timer_defines.vh"
module cdt_timer #(
  // Identification word; value is arbitrary
  parameter [31:0] ID_VALUE = 32'h71e0c0de
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire dbg_halt,
  output wire timer_irq
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  localparam [3:0] SEL_NONE = 4'h0;
  localparam [3:0] SEL_LOAD = 4'h1;
  localparam [3:0] SEL_VALUE = 4'h2;
  localparam [3:0] SEL_CLR = 4'h3;
  localparam [3:0] SEL_CTL = 4'h4;
  localparam [3:0] SEL_RAW = 4'h5;
  localparam [3:0] SEL_MSK = 4'h6;
  localparam [3:0] SEL_RELOAD = 4'h7;
  localparam [3:0] SEL_PREDIV = 4'h8;
  localparam [3:0] SEL_FREE = 4'h9;

  function [3:0] reg_sel;
    input [11:0] a;
    begin
      case (a)
        `CDT_OFF_LOAD: reg_sel = SEL_LOAD;
        `CDT_OFF_VALUE: reg_sel = SEL_VALUE;
        `CDT_OFF_IRQ_CLEAR: reg_sel = SEL_CLR;
        `CDT_OFF_CONTROL: reg_sel = SEL_CTL;
        `CDT_OFF_RAW_IRQ: reg_sel = SEL_RAW;
        `CDT_OFF_MASKED_IRQ: reg_sel = SEL_MSK;
        `CDT_OFF_RELOAD: reg_sel = SEL_RELOAD;
        `CDT_OFF_PREDIV: reg_sel = SEL_PREDIV;
        `CDT_OFF_FREE_RUN: reg_sel = SEL_FREE;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  reg [31:0] ctl_r;
  reg [31:0] load_r;
  reg [31:0] value_r;
  reg [9:0] prediv_r;
  reg [31:0] free_r;
  reg pend_r;
  reg [7:0] pre_cnt_r;

  wire halt_sync;
  wire wr_access;
  wire rd_setup;
  wire [3:0] wr_sel;
  wire [3:0] rd_sel;

  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_sel = wr_access ? reg_sel(paddr) : SEL_NONE;
  assign rd_sel = reg_sel(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (reg_sel(paddr) == SEL_NONE);

  // ----------------------------------------
  // Debug halt and tick generation
  // ----------------------------------------
  cdt_sync u_halt_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(dbg_halt),
    .level_r(halt_sync)
  );

  wire frozen;
  wire cd_run;
  wire fr_run;
  wire base_tick;
  wire fr_tick;
  reg cd_tick;

  assign frozen = ctl_r[`CDT_CTL_DBG_HALT] & halt_sync;
  assign cd_run = ctl_r[`CDT_CTL_EN] & ~frozen;
  assign fr_run = ctl_r[`CDT_CTL_FR_EN] & ~frozen;

  cdt_div #(.W(10)) u_tick_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(cd_run),
    .div(prediv_r),
    .tick(base_tick)
  );

  cdt_div #(.W(8)) u_free_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(fr_run),
    .div(ctl_r[`CDT_CTL_FR_PRE_HI:`CDT_CTL_FR_PRE_LO]),
    .tick(fr_tick)
  );

  // Codes 00 and 11 pass every base tick through
  always @* begin
    case (ctl_r[`CDT_CTL_PRE_HI:`CDT_CTL_PRE_LO])
      `CDT_PRE_DIV16: cd_tick = base_tick & (pre_cnt_r[3:0] == 4'hf);
      `CDT_PRE_DIV256: cd_tick = base_tick & (pre_cnt_r == 8'hff);
      default: cd_tick = base_tick;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 8'h00;
    end else if (base_tick) begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------
  // Countdown and pending flag
  // ----------------------------------------
  wire wide;
  wire [31:0] value_eff;
  wire at_zero;
  wire zero_event;
  wire [31:0] wmask;

  assign wide = ctl_r[`CDT_CTL_WIDE];
  assign wmask = wide ? 32'hffffffff : 32'h0000ffff;
  assign value_eff = value_r & wmask;
  assign at_zero = (value_eff == 32'h00000000);
  assign zero_event = cd_tick & at_zero;

  reg [31:0] value_nxt;
  always @* begin
    value_nxt = value_r;
    if (zero_event) begin
      value_nxt = load_r & wmask;
    end else if (cd_tick) begin
      value_nxt = (value_r - 32'h00000001) & wmask;
    end
    // A direct load write overrides the tick in the same cycle
    if (wr_sel == SEL_LOAD) begin
      value_nxt = pwdata & wmask;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= 32'h00000000;
    end else begin
      value_r <= value_nxt;
    end
  end

  // A zero event in the clearing cycle wins, so no expiry is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
    end else if (zero_event) begin
      pend_r <= 1'b1;
    end else if (wr_sel == SEL_CLR) begin
      pend_r <= 1'b0;
    end
  end

  assign timer_irq = pend_r & ctl_r[`CDT_CTL_IE];

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= `CDT_CTL_RESET;
      load_r <= 32'h00000000;
      prediv_r <= `CDT_PREDIV_RESET;
    end else begin
      if (wr_sel == SEL_CTL) begin
        ctl_r <= pwdata & `CDT_CTL_MASK;
      end
      if ((wr_sel == SEL_LOAD) || (wr_sel == SEL_RELOAD)) begin
        load_r <= pwdata;
      end
      if (wr_sel == SEL_PREDIV) begin
        prediv_r <= pwdata[9:0];
      end
    end
  end

  // Free-running counter has no software clear and simply wraps
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_r <= 32'h00000000;
    end else if (fr_tick) begin
      free_r <= free_r + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg [31:0] rd_nxt;
  always @* begin
    case (rd_sel)
      SEL_LOAD: rd_nxt = load_r;
      SEL_RELOAD: rd_nxt = load_r;
      SEL_VALUE: rd_nxt = value_eff;
      SEL_CLR: rd_nxt = ID_VALUE;
      SEL_CTL: rd_nxt = ctl_r;
      SEL_RAW: rd_nxt = {31'h0, pend_r};
      SEL_MSK: rd_nxt = {31'h0, timer_irq};
      SEL_PREDIV: rd_nxt = {22'h0, prediv_r};
      SEL_FREE: rd_nxt = free_r;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Data is captured in setup so the access phase presents a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_nxt;
    end
  end

endmodule // cdt_timer

/* verilog/cdt_timer_defines.vh */
// Purpose: Register map, field positions, reset values of the countdown timer
// Assumes: Byte addresses within the timer window, 32-bit APB data
// Notes:   Definitions only
`ifndef CDT_TIMER_DEFINES_VH
`define CDT_TIMER_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CDT_OFF_LOAD 12'h400
`define CDT_OFF_VALUE 12'h404
`define CDT_OFF_IRQ_CLEAR 12'h408
`define CDT_OFF_CONTROL 12'h40c
`define CDT_OFF_RAW_IRQ 12'h410
`define CDT_OFF_MASKED_IRQ 12'h414
`define CDT_OFF_RELOAD 12'h418
`define CDT_OFF_PREDIV 12'h41c
`define CDT_OFF_FREE_RUN 12'h420

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CDT_CTL_FR_PRE_HI 23
`define CDT_CTL_FR_PRE_LO 16
`define CDT_CTL_FR_EN 9
`define CDT_CTL_DBG_HALT 8
`define CDT_CTL_EN 7
`define CDT_CTL_PERIODIC 6
`define CDT_CTL_IE 5
`define CDT_CTL_PRE_HI 3
`define CDT_CTL_PRE_LO 2
`define CDT_CTL_WIDE 1
`define CDT_CTL_ONESHOT 0
`define CDT_CTL_MASK 32'h00ff03ef

// ----------------------------------------
// Reset values and prescale codes
// ----------------------------------------
`define CDT_CTL_RESET 32'h003e0020
`define CDT_PREDIV_RESET 10'h07d
`define CDT_PRE_DIV16 2'h1
`define CDT_PRE_DIV256 2'h2

`endif
